/* rtl/piu_pkg.sv */
// Types shared by the interrupt unit files
package piu_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } piu_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } piu_wb_rsp_type;

  typedef struct packed {
    logic       power_down;
    logic       master_clear;
    logic       io_level_line_two;
    logic       io_level_line_one;
    logic [5:0] user_request_line;
  } piu_pin_type;

  typedef struct packed {
    logic machine_error;
    logic float_overflow;
    logic fixed_overflow;
    logic executive_call;
    logic float_underflow;
    logic timer_a;
    logic timer_b;
  } piu_core_event_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } piu_pc_load_type;

  typedef enum logic [3:0] {
    piu_idle    = 4'b0001,
    piu_save    = 4'b0010,
    piu_disable = 4'b0100,
    piu_load    = 4'b1000
  } piu_state_type;

endpackage : piu_pkg

/* rtl/piu_regs.svh */
// Register offsets, field positions, reset values and level constants of the interrupt unit
`ifndef PIU_REGS_SVH
`define PIU_REGS_SVH

// ==================================================
// Register byte offsets
`define PIU_ADR_PENDING    8'h00
`define PIU_ADR_MASK       8'h04
`define PIU_ADR_CTRL       8'h08
`define PIU_ADR_SAVE       8'h0c
`define PIU_ADR_PC         8'h10
`define PIU_ADR_INT_STAT   8'h14
`define PIU_ADR_INT_MASK   8'h18

// ==================================================
// Fields and reset values
`define PIU_CTRL_ENABLE    0
`define PIU_STAT_TAKEN     0
`define PIU_STAT_OVERWRITE 1
`define PIU_STAT_CALL      2
`define PIU_STAT_WIDTH     3
`define PIU_RST_MASK       16'h0000
`define PIU_RST_PC         16'h0000
`define PIU_RST_STAT       3'h0

// ==================================================
// Level properties
`define PIU_LEVELS         16
`define PIU_LEVEL_TRIG     16'h0068
`define PIU_NO_MASK        16'h0021
`define PIU_NO_DISABLE     16'h0023
`define PIU_CLEAR_ON_MCLR  16'h0021
`define PIU_VEC_BASE       16'h0400
`define PIU_VEC_SHIFT      2
`define PIU_TIMER_A_LVL    7
`define PIU_TIMER_B_LVL    9

`endif

/* rtl/piu_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module piu_sync #(
  parameter int WIDTH = 10
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ==================================================
  // Per-bit synchroniser
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : piu_sync

/* rtl/priority_interrupt_unit.sv */
// Sixteen-level prioritised interrupt unit with vectoring and a classic Wishbone register slave
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "piu_regs.svh"

// Functional notes
// - Sixteen levels 0..15, fixed priority, level 0 highest, 15 lowest.
// - Eight levels come from external lines; the rest are internal sources.
// - User lines go to levels 2,8,10,11,13,15; I/O lines to 12 and 14.
// - Internal: 0 power-down,1 error,3/4 overflows,5 exec call,6 underflow,7/9 timers.
// - Master clear clears pending levels 0 and 5.
// - All levels edge-detected except 3, 5 and 6, taken from the condition.
// - An active level sets and holds its pending bit, readable by software.
// - On redirect: save program counter, then disable interrupts, then load vector.
// - Vector of level n is 0400 hex plus four times n.
// - Levels 0 and 5 are never masked and never disabled.
// - Level 1 maskable but not disableable; the others are both.
// - Subroutine call also writes the program counter into the save register.
// - A new interrupt after re-enable overwrites the saved return address.
// - One mask bit per level; a cleared mask bit ignores that level, except for levels 0 and 5.
module priority_interrupt_unit
  import piu_pkg::*;
#(
  parameter logic TIMER_A_PRESENT = 1'b1,
  parameter logic TIMER_B_PRESENT = 1'b1
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire piu_wb_req_type     wb_req,
  output piu_wb_rsp_type          wb_rsp,
  input  wire logic               user_request_line_a,
  input  wire logic               user_request_line_b,
  input  wire logic               user_request_line_c,
  input  wire logic               user_request_line_d,
  input  wire logic               user_request_line_e,
  input  wire logic               user_request_line_f,
  input  wire logic               io_level_line_one,
  input  wire logic               io_level_line_two,
  input  wire logic               power_down,
  input  wire logic               master_clear,
  input  wire piu_core_event_type core_event,
  input  wire logic               call_strobe,
  input  wire piu_pc_load_type    pc_load,
  output logic [15:0]             program_counter,
  output logic [15:0]             return_save_register,
  output logic                    redirect,
  output logic                    interrupts_enabled,
  output logic                    irq
);

  // ==================================================
  // Declarations
  localparam int NL = `PIU_LEVELS;

  piu_pin_type               pin_raw;
  piu_pin_type               pin_sync;
  logic [NL-1:0]             source;
  logic [NL-1:0]             source_prev;
  logic [NL-1:0]             request;
  logic [NL-1:0]             pending_request_word;
  logic [NL-1:0]             level_mask_word;
  logic [NL-1:0]             eligible;
  logic [3:0]                winner;
  logic                      any_eligible;
  logic [3:0]                taken_level;
  logic [NL-1:0]             take_clear;
  piu_state_type             state;
  piu_state_type             next_state;
  logic                      save_unread;
  logic [`PIU_STAT_WIDTH-1:0] int_status;
  logic [`PIU_STAT_WIDTH-1:0] int_mask;
  logic [`PIU_STAT_WIDTH-1:0] stat_set;
  logic                      bus_req;
  logic                      bus_wr;
  logic                      bus_rd;
  logic [15:0]               wr_lo16;
  logic [31:0]               next_rdata;

  // ==================================================
  // Pin synchronisation
  assign pin_raw.power_down        = power_down;
  assign pin_raw.master_clear      = master_clear;
  assign pin_raw.io_level_line_two = io_level_line_two;
  assign pin_raw.io_level_line_one = io_level_line_one;
  assign pin_raw.user_request_line = {user_request_line_f, user_request_line_e, user_request_line_d,
                                      user_request_line_c, user_request_line_b, user_request_line_a};

  piu_sync #(
    .WIDTH ($bits(piu_pin_type))
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  // ==================================================
  // Level source map
  always_comb begin
    source     = '0;
    source[0]  = pin_sync.power_down;
    source[1]  = core_event.machine_error;
    source[2]  = pin_sync.user_request_line[0];
    source[3]  = core_event.float_overflow;
    source[4]  = core_event.fixed_overflow;
    source[5]  = core_event.executive_call;
    source[6]  = core_event.float_underflow;
    source[`PIU_TIMER_A_LVL] = core_event.timer_a & TIMER_A_PRESENT;
    source[8]  = pin_sync.user_request_line[1];
    source[`PIU_TIMER_B_LVL] = core_event.timer_b & TIMER_B_PRESENT;
    source[10] = pin_sync.user_request_line[2];
    source[11] = pin_sync.user_request_line[3];
    source[12] = pin_sync.io_level_line_one;
    source[13] = pin_sync.user_request_line[4];
    source[14] = pin_sync.io_level_line_two;
    source[15] = pin_sync.user_request_line[5];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      source_prev <= '0;
    end else begin
      source_prev <= source;
    end
  end

  // ==================================================
  // Request detection and pending latch
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_level
      localparam logic LEVEL_TRIG = 1'(`PIU_LEVEL_TRIG >> g);
      localparam logic NO_MASK    = 1'(`PIU_NO_MASK >> g);
      localparam logic NO_DIS     = 1'(`PIU_NO_DISABLE >> g);
      localparam logic MCLR_CLR   = 1'(`PIU_CLEAR_ON_MCLR >> g);

      if (LEVEL_TRIG) begin : g_lvl
        assign request[g] = source[g];
      end else begin : g_edge
        assign request[g] = source[g] & ~source_prev[g];
      end

      // Permission per level
      assign eligible[g] = pending_request_word[g] &
                           (NO_MASK | level_mask_word[g]) &
                           (NO_DIS | interrupts_enabled);

      // Set wins over a take or software clear; master clear empties levels 0 and 5
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pending_request_word[g] <= 1'b0;
        end else if (MCLR_CLR && pin_sync.master_clear) begin
          pending_request_word[g] <= 1'b0;
        end else if (request[g]) begin
          pending_request_word[g] <= 1'b1;
        end else if (take_clear[g] ||
                     (bus_wr && wb_req.adr == `PIU_ADR_PENDING && wr_lo16[g])) begin
          pending_request_word[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==================================================
  // Priority selection: lowest number wins
  always_comb begin
    winner       = 4'h0;
    any_eligible = 1'b0;
    for (int i = NL - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        winner       = 4'(i);
        any_eligible = 1'b1;
      end
    end
  end

  // ==================================================
  // Redirect sequencer
  always_comb begin
    next_state = state;
    case (state)
      piu_idle:    if (any_eligible) next_state = piu_save;
      piu_save:    next_state = piu_disable;
      piu_disable: next_state = piu_load;
      piu_load:    next_state = piu_idle;
      default:     next_state = piu_idle;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= piu_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      taken_level <= 4'h0;
    end else if (state == piu_idle && any_eligible) begin
      taken_level <= winner;
    end
  end

  always_comb begin
    take_clear = '0;
    if (state == piu_idle && any_eligible) begin
      take_clear[winner] = 1'b1;
    end
  end

  // Program counter: vector load beats a core load in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      program_counter <= `PIU_RST_PC;
    end else if (state == piu_load) begin
      program_counter <= `PIU_VEC_BASE + {10'h000, taken_level, 2'b00};
    end else if (bus_wr && wb_req.adr == `PIU_ADR_PC) begin
      program_counter <= wr_lo16;
    end else if (pc_load.valid) begin
      program_counter <= pc_load.value;
    end
  end

  // Interrupt save wins over a call landing in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      return_save_register <= `PIU_RST_PC;
    end else if (state == piu_save) begin
      return_save_register <= program_counter;
    end else if (call_strobe) begin
      return_save_register <= program_counter;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      save_unread <= 1'b0;
    end else if (state == piu_save || call_strobe) begin
      save_unread <= 1'b1;
    end else if (bus_rd && wb_req.adr == `PIU_ADR_SAVE) begin
      save_unread <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupts_enabled <= 1'b0;
    end else if (state == piu_disable) begin
      interrupts_enabled <= 1'b0;
    end else if (bus_wr && wb_req.adr == `PIU_ADR_CTRL && wb_req.sel[0]) begin
      interrupts_enabled <= wb_req.dat[`PIU_CTRL_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      redirect <= 1'b0;
    end else begin
      redirect <= (state == piu_load);
    end
  end

  // ==================================================
  // Wishbone slave: one wait state, ack for one cycle
  assign bus_req = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  assign bus_wr  = bus_req & wb_req.we;
  assign bus_rd  = bus_req & ~wb_req.we;

  always_comb begin
    wr_lo16[7:0]  = wb_req.sel[0] ? wb_req.dat[7:0] : 8'h00;
    wr_lo16[15:8] = wb_req.sel[1] ? wb_req.dat[15:8] : 8'h00;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_mask_word <= `PIU_RST_MASK;
    end else if (bus_wr && wb_req.adr == `PIU_ADR_MASK) begin
      if (wb_req.sel[0]) begin
        level_mask_word[7:0] <= wb_req.dat[7:0];
      end
      if (wb_req.sel[1]) begin
        level_mask_word[15:8] <= wb_req.dat[15:8];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_req.adr)
      `PIU_ADR_PENDING:  next_rdata[15:0] = pending_request_word;
      `PIU_ADR_MASK:     next_rdata[15:0] = level_mask_word;
      `PIU_ADR_CTRL:     next_rdata[`PIU_CTRL_ENABLE] = interrupts_enabled;
      `PIU_ADR_SAVE:     next_rdata[15:0] = return_save_register;
      `PIU_ADR_PC:       next_rdata[15:0] = program_counter;
      `PIU_ADR_INT_STAT: next_rdata[`PIU_STAT_WIDTH-1:0] = int_status;
      `PIU_ADR_INT_MASK: next_rdata[`PIU_STAT_WIDTH-1:0] = int_mask;
      default:           next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= bus_req;
      if (bus_rd) begin
        wb_rsp.dat <= next_rdata;
      end
    end
  end

  // ==================================================
  // Unit interrupt: sticky events, read to clear, set wins
  always_comb begin
    stat_set                      = '0;
    stat_set[`PIU_STAT_TAKEN]     = (state == piu_load);
    stat_set[`PIU_STAT_OVERWRITE] = save_unread & (state == piu_save || call_strobe);
    stat_set[`PIU_STAT_CALL]      = call_strobe;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= `PIU_RST_STAT;
    end else if (bus_rd && wb_req.adr == `PIU_ADR_INT_STAT) begin
      int_status <= stat_set;
    end else begin
      int_status <= int_status | stat_set;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_mask <= `PIU_RST_STAT;
    end else if (bus_wr && wb_req.adr == `PIU_ADR_INT_MASK && wb_req.sel[0]) begin
      int_mask <= wb_req.dat[`PIU_STAT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

endmodule : priority_interrupt_unit

/* tb/piu_checker_assertions.sv */
// Port checks of the interrupt unit
`timescale 1ns/1ps
module piu_checker
  import piu_pkg::*;
(
  input wire logic            clk,
  input wire logic            nrst,
  input wire piu_wb_req_type  wb_req,
  input wire piu_wb_rsp_type  wb_rsp,
  input wire piu_pc_load_type pc_load,
  input wire logic [15:0]     program_counter,
  input wire logic            redirect,
  input wire logic            interrupts_enabled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==================================================
  // Sequences
  sequence bus_taken;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence vector_loaded;
    redirect && !interrupts_enabled;
  endsequence

  // ==================================================
  // Properties
  a_ack_next: assert property (bus_taken |=> wb_rsp.ack) else $error("ack missing");
  a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
  a_unmapped_zero: assert property (bus_taken and (!wb_req.we && wb_req.adr == 8'h1c) |=> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
  a_redirect_spacing: assert property (redirect |=> !redirect [*3]) else $error("redirect too close");
  a_load_disabled: assert property (redirect |-> !interrupts_enabled) else $error("redirect while on");
  a_vector_range: assert property (redirect |->
    program_counter[15:6] == 10'h010 && program_counter[1:0] == 2'h0) else $error("bad vector");
  a_disable_then_load: assert property ($fell(interrupts_enabled) && !wb_rsp.ack |=> vector_loaded)
    else $error("no load after disable");
  a_pc_load_takes: assert property (pc_load.valid && !wb_req.stb |=> redirect || program_counter == $past(pc_load.value))
    else $error("pc load lost");
  a_reset_quiet: assert property ($rose(nrst) |-> program_counter == 16'h0 && !redirect && !wb_rsp.ack)
    else $error("outputs busy after reset");
endmodule : piu_checker

bind priority_interrupt_unit piu_checker piu_checker_i (
  .clk                (clk),
  .nrst               (nrst),
  .wb_req             (wb_req),
  .wb_rsp             (wb_rsp),
  .pc_load            (pc_load),
  .program_counter    (program_counter),
  .redirect           (redirect),
  .interrupts_enabled (interrupts_enabled)
);

/* tb/piu_source_model.sv */
// Model of the external lines and on-chip event sources of the interrupt unit
`timescale 1ns/1ps
module piu_source_model
  import piu_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          fire,
  input  wire logic [3:0]    lvl,
  output logic [5:0]         user_line,
  output logic [1:0]         io_line,
  output logic               power_down,
  output piu_core_event_type core_event
);
  // ==================================================
  // Pins stay high four cycles so the synchroniser sees them; core events last one cycle
  logic [15:0] act  = 16'h0;
  logic [15:0] one  = 16'h0;
  logic [2:0]  hold = 3'd0;

  always @(posedge clk) begin
    one  <= fire ? 16'h1 << lvl : 16'h0;
    hold <= fire ? 3'd4 : hold - 3'(hold != 3'd0);
    if (fire) begin
      act <= 16'h1 << lvl;
    end else if (hold == 3'd1) begin
      act <= 16'h0;
    end
  end

  assign user_line  = {act[15], act[13], act[11], act[10], act[8], act[2]};
  assign io_line    = {act[14], act[12]};
  assign power_down = act[0];
  assign core_event = {one[1], one[3], one[4], one[5], one[6], one[7], one[9]};
endmodule : piu_source_model

/* tb/priority_interrupt_unit_tb_top.sv */
// Self-checking bench of the interrupt unit
`timescale 1ns/1ps
`include "piu_regs.svh"
module priority_interrupt_unit_tb_top
  import piu_pkg::*;
;
  logic               clk, nrst, call_strobe, master_clear, fire, redirect, interrupts_enabled, irq, got, power_down;
  piu_wb_req_type     wb_req;
  piu_wb_rsp_type     wb_rsp;
  piu_pc_load_type    pc_load;
  piu_core_event_type core_event;
  logic [15:0]        program_counter, return_save_register, p;
  logic [5:0]         user_line;
  logic [1:0]         io_line;
  logic [3:0]         lvl;
  logic [31:0]        q;
  logic [3:0]         tl [4] = '{4'd1, 4'd0, 4'd5, 4'd1};
  int                 n_mismatch = 0;
  int                 n_compared = 0;
  int                 cycles = 0;

  priority_interrupt_unit priority_interrupt_unit_i (.clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .user_request_line_a(user_line[0]), .user_request_line_b(user_line[1]), .user_request_line_c(user_line[2]),
    .user_request_line_d(user_line[3]), .user_request_line_e(user_line[4]), .user_request_line_f(user_line[5]),
    .io_level_line_one(io_line[0]), .io_level_line_two(io_line[1]), .power_down(power_down),
    .master_clear(master_clear), .core_event(core_event), .call_strobe(call_strobe), .pc_load(pc_load),
    .program_counter(program_counter), .return_save_register(return_save_register), .redirect(redirect),
    .interrupts_enabled(interrupts_enabled), .irq(irq));
  piu_source_model piu_source_model_i (.clk(clk), .fire(fire), .lvl(lvl), .user_line(user_line),
    .io_line(io_line), .power_down(power_down), .core_event(core_event));

  // ==================================================
  // Clock, timeout and helpers
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  function automatic logic [15:0] vec(input int l);
    return `PIU_VEC_BASE + 16'(l * 4);
  endfunction : vec

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    do @(posedge clk); while (wb_rsp.ack !== 1'b1);
    r = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  task automatic raise(input logic [3:0] l);
    @(posedge clk);
    fire <= 1'b1;
    lvl  <= l;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : raise

  task automatic wait_redirect(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && got == 1'b0; i++) begin
      @(posedge clk);
      got = (redirect === 1'b1);
    end
  endtask : wait_redirect

  task final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // ==================================================
  // Tests
  initial begin
    wb_req = '0;
    pc_load = '0;
    call_strobe = 1'b0;
    master_clear = 1'b0;
    fire = 1'b0;
    lvl = 4'h0;
    nrst = 1'b0;
    void'($urandom(25));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, q);
      check(q, 32'h0);
    end
    $display("test reset done");
    wb(1'b1, `PIU_ADR_MASK, 32'hffff, q);
    wb(1'b1, `PIU_ADR_INT_MASK, 32'h1, q);
    for (int l = 0; l < 16; l++) begin
      p = 16'($urandom);
      wb(1'b1, `PIU_ADR_PC, {16'h0, p}, q);
      wb(1'b1, `PIU_ADR_CTRL, 32'h1, q);
      raise(4'(l));
      wait_redirect(30);
      check(32'(got), 32'h1);
      check(32'(program_counter), 32'(vec(l)));
      check(32'(return_save_register), 32'(p));
      check(32'(interrupts_enabled), 32'h0);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h1);
      wb(1'b0, `PIU_ADR_INT_STAT, 32'h0, q);
      check(q, {30'h0, l != 0, 1'b1});
      @(posedge clk);
      check(32'(irq), 32'h0);
    end
    $display("test vectors done");
    wb(1'b1, `PIU_ADR_CTRL, 32'h0, q);
    raise(4'd8);
    raise(4'd2);
    wb(1'b0, `PIU_ADR_PENDING, 32'h0, q);
    check(q, 32'h104);
    wb(1'b1, `PIU_ADR_CTRL, 32'h1, q);
    wait_redirect(30);
    check(32'(program_counter), 32'(vec(2)));
    wb(1'b0, `PIU_ADR_PENDING, 32'h0, q);
    check(q, 32'h100);
    $display("test priority done");
    wb(1'b1, `PIU_ADR_PENDING, 32'hffff, q);
    wb(1'b1, `PIU_ADR_MASK, 32'hfffb, q);
    wb(1'b1, `PIU_ADR_CTRL, 32'h1, q);
    raise(4'd2);
    wait_redirect(20);
    check(32'(got), 32'h0);
    wb(1'b1, `PIU_ADR_CTRL, 32'h0, q);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `PIU_ADR_MASK, k == 0 ? 32'h2 : 32'h0, q);
      raise(tl[k]);
      wait_redirect(30);
      check(32'(got), 32'(k != 3));
      if (k != 3) check(32'(program_counter), 32'(vec(tl[k])));
    end
    $display("test masking done");
    wb(1'b1, `PIU_ADR_PENDING, 32'hffff, q);
    master_clear <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      raise(k == 0 ? 4'd0 : 4'd5);
      wait_redirect(12);
      check(32'(got), 32'h0);
    end
    wb(1'b0, `PIU_ADR_PENDING, 32'h0, q);
    check(q, 32'h0);
    master_clear <= 1'b0;
    $display("test master clear done");
    wb(1'b1, `PIU_ADR_INT_MASK, 32'h0, q);
    p = 16'($urandom);
    pc_load <= '{valid: 1'b1, value: p};
    @(posedge clk);
    pc_load <= '0;
    call_strobe <= 1'b1;
    @(posedge clk);
    call_strobe <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(program_counter), 32'(p));
    check(32'(return_save_register), 32'(p));
    check(32'(irq), 32'h0);
    wb(1'b1, `PIU_ADR_INT_MASK, 32'h4, q);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h1);
    wb(1'b0, `PIU_ADR_INT_STAT, 32'h0, q);
    check(q & 32'h4, 32'h4);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    $display("test call done");
    final_report();
  end
endmodule : priority_interrupt_unit_tb_top
